//--- rtl/ext_irq_pkg.sv
// Shared constants, register map and carrier types for the external interrupt selector
package ext_irq_pkg;
	localparam int NUM_PINS = 46;
	localparam int NUM_EXT = 8;
	localparam int NUM_SRC = 10;
	localparam int ADDR_W = 12;
	// Printed register indices; byte address is four times the index
	localparam logic [7:0] IDX_LEGACY1_PIN_SELECT = 8'h8E;
	localparam logic [7:0] IDX_LEGACY0_PIN_SELECT = 8'h8F;
	localparam logic [7:0] IDX_EXT_SOURCE_ENABLE = 8'hF9;
	localparam logic [7:0] IDX_EXT_PENDING_FLAGS = 8'hFA;
	localparam logic [7:0] IDX_EXT_ENTRY_CONFIG = 8'hFB;
	localparam logic [7:0] IDX_EXT_PRIORITY = 8'hF8;
	localparam logic [7:0] IDX_VECTOR_ENABLE = 8'hE8;
	localparam logic [7:0] IDX_ENTRY_INDEX = 8'hC0;
	localparam logic [7:0] IDX_LEGACY_CONTROL = 8'hC1;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hC2;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'hC3;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC4;
	// Field positions
	localparam int CFG_POLARITY_BIT = 7;
	localparam int LCTL_EDGE0_BIT = 0;
	localparam int LCTL_EDGE1_BIT = 1;
	localparam int LCTL_PRIO0_BIT = 2;
	localparam int LCTL_PRIO1_BIT = 3;
	// Reset values and AXI response codes
	localparam logic [4:0] LEGACY0_PIN_RESET = 5'h1A;
	localparam logic [4:0] LEGACY1_PIN_RESET = 5'h1B;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Edge and pin choice of one source
	typedef struct packed {
		logic edge_polarity;
		logic [5:0] entry_pin_index;
	} entry_cfg_type;

	// State of the selector apart from the edge units
	typedef struct packed {
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NUM_PINS-1:0] sync1;
		logic [NUM_PINS-1:0] sync2;
		logic [4:0] legacy0_pin_index;
		logic [4:0] legacy1_pin_index;
		logic [3:0] legacy_control;
		logic [7:0] ext_source_enable;
		logic [7:0] ext_pending_flags;
		logic [7:0] ext_priority;
		logic [7:0] vector_enable;
		logic [2:0] entry_index;
		entry_cfg_type [NUM_EXT-1:0] entry_cfg;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic vec_valid;
		logic [3:0] vec_id;
		logic wake;
	} state_type;

	// Edge unit state
	typedef struct packed {
		logic prev;
		logic [5:0] last_index;
	} edge_state_type;
endpackage : ext_irq_pkg

//--- rtl/external_interrupt_select.sv
// External interrupt selector: pin routing, edge flags, enables, priority and AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// - Priority register bit 7..0 maps entry 9..2; 1 means high priority.
// - Legacy source 0 uses the pin named by its five-bit pin select.
// - Legacy source 1 uses the pin named by its own five-bit pin select.
// - Eight extended entries 2..9 each pick any pin independently.
// - Config bit 7 picks the edge: 0 rising, 1 falling.
// - Config bits 5..0 hold the entry's pin index.
// - Configs share one address; the index register 0..7 selects entry index+2.
// - Pin index is port times eight plus bit, covering 0 to 45.
// - Source enable bit 0..7 covers entries 2..9, reset to disabled.
// - Pending flag bit 0..7 covers entries 2..9; writing 1 clears, 0 keeps.
// - Detected edges raise a wake request for leaving stop mode.
// - Legacy sources each have their own rising or falling edge select.
// - An entry requests only with both vector and source enables set.
// - High priority wins, then the lowest vector number.
module external_interrupt_select import ext_irq_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NUM_PINS-1:0] port_pins,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [NUM_EXT-1:0] ext_request,
	output logic legacy_ext_irq0,
	output logic legacy_ext_irq1,
	output logic vec_valid,
	output logic [3:0] vec_id,
	output logic wake_request,
	output logic irq
);
	state_type st;
	state_type next_st;
	entry_cfg_type [NUM_SRC-1:0] src_cfg;
	logic [NUM_SRC-1:0] src_edge;
	logic [NUM_EXT-1:0] ext_edge;
	logic [NUM_SRC-1:0] req10;
	logic [NUM_SRC-1:0] prio10;
	logic do_write;
	logic wr_en;
	logic [ADDR_W-1:0] ar_addr;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'h0, idx, 2'h0};
	endfunction : reg_addr

	// Register read view; write-only and unmapped words read as zero
	function automatic logic [31:0] read_word(input state_type s, input logic [ADDR_W-1:0] a);
		logic [7:0] v;
		entry_cfg_type c;
		v = 8'h00;
		c = s.entry_cfg[s.entry_index];
		case (a)
			reg_addr(IDX_LEGACY0_PIN_SELECT): v = {3'h0, s.legacy0_pin_index};
			reg_addr(IDX_LEGACY1_PIN_SELECT): v = {3'h0, s.legacy1_pin_index};
			reg_addr(IDX_EXT_SOURCE_ENABLE): v = s.ext_source_enable;
			reg_addr(IDX_EXT_PENDING_FLAGS): v = s.ext_pending_flags;
			reg_addr(IDX_EXT_ENTRY_CONFIG): v = {c.edge_polarity, 1'b0, c.entry_pin_index};
			reg_addr(IDX_EXT_PRIORITY): v = s.ext_priority;
			reg_addr(IDX_VECTOR_ENABLE): v = s.vector_enable;
			reg_addr(IDX_ENTRY_INDEX): v = {5'h00, s.entry_index};
			reg_addr(IDX_LEGACY_CONTROL): v = {4'h0, s.legacy_control};
			reg_addr(IDX_IRQ_STATUS): v = {6'h00, s.irq_status};
			reg_addr(IDX_IRQ_ENABLE): v = {6'h00, s.irq_enable};
			default: v = 8'h00;
		endcase
		read_word = {24'h000000, v};
	endfunction : read_word

	// Whether an address names a register at all
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (a)
			reg_addr(IDX_LEGACY0_PIN_SELECT), reg_addr(IDX_LEGACY1_PIN_SELECT),
			reg_addr(IDX_EXT_SOURCE_ENABLE), reg_addr(IDX_EXT_PENDING_FLAGS),
			reg_addr(IDX_EXT_ENTRY_CONFIG), reg_addr(IDX_EXT_PRIORITY),
			reg_addr(IDX_VECTOR_ENABLE), reg_addr(IDX_ENTRY_INDEX),
			reg_addr(IDX_LEGACY_CONTROL), reg_addr(IDX_IRQ_STATUS),
			reg_addr(IDX_IRQ_CLEAR), reg_addr(IDX_IRQ_ENABLE): mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// Source table: slots 0 and 1 legacy, slots 2..9 the extended entries
	always_comb begin
		src_cfg[0] = '{edge_polarity: st.legacy_control[LCTL_EDGE0_BIT],
			entry_pin_index: {1'b0, st.legacy0_pin_index}};
		src_cfg[1] = '{edge_polarity: st.legacy_control[LCTL_EDGE1_BIT],
			entry_pin_index: {1'b0, st.legacy1_pin_index}};
		for (int i = 0; i < NUM_EXT; i++) begin
			src_cfg[i+2] = st.entry_cfg[i];
		end
	end

	// One edge unit per source, all fed from the synchronised pin bus
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gen_src
			pin_edge_detect #(.PINS(NUM_PINS)) u_edge (
				.aclk(aclk),
				.aresetn(aresetn),
				.pins(st.sync2),
				.cfg(src_cfg[g]),
				.edge_seen(src_edge[g])
			);
		end
	endgenerate

	assign ext_edge = src_edge[NUM_SRC-1:2];
	// Extended requests to the CPU need both enable levels; legacy requests need only their irq enable
	assign ext_request = st.ext_pending_flags & st.ext_source_enable & st.vector_enable;
	assign legacy_ext_irq0 = st.irq_status[0] & st.irq_enable[0];
	assign legacy_ext_irq1 = st.irq_status[1] & st.irq_enable[1];
	assign req10 = {ext_request, legacy_ext_irq1, legacy_ext_irq0};
	assign prio10 = {st.ext_priority, st.legacy_control[LCTL_PRIO1_BIT], st.legacy_control[LCTL_PRIO0_BIT]};

	// Handshake outputs; one write and one read in flight at most
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign do_write = st.aw_held && st.w_held && !st.bvalid;
	assign wr_en = do_write && st.w_strb0;
	assign ar_addr = s_axi_araddr;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign vec_valid = st.vec_valid;
	assign vec_id = st.vec_id;
	assign wake_request = st.wake;
	assign irq = |req10;

	// Next state
	always_comb begin
		logic [7:0] ext_clr;
		logic [1:0] irq_clr;
		logic hf;
		logic lf;
		logic [3:0] hid;
		logic [3:0] lid;
		next_st = st;
		ext_clr = 8'h00;
		irq_clr = 2'h0;
		hf = 1'b0;
		lf = 1'b0;
		hid = 4'h0;
		lid = 4'h0;
		// First flop feeds only the second
		next_st.sync1 = port_pins;
		next_st.sync2 = st.sync1;

		// Address and data are latched in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata[7:0];
			next_st.w_strb0 = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_en) begin
			case (st.aw_addr)
				reg_addr(IDX_LEGACY0_PIN_SELECT): next_st.legacy0_pin_index = st.w_data[4:0];
				reg_addr(IDX_LEGACY1_PIN_SELECT): next_st.legacy1_pin_index = st.w_data[4:0];
				reg_addr(IDX_EXT_SOURCE_ENABLE): next_st.ext_source_enable = st.w_data;
				reg_addr(IDX_EXT_PENDING_FLAGS): ext_clr = st.w_data;
				reg_addr(IDX_EXT_ENTRY_CONFIG): begin
					next_st.entry_cfg[st.entry_index] = '{edge_polarity: st.w_data[CFG_POLARITY_BIT],
						entry_pin_index: st.w_data[5:0]};
				end
				reg_addr(IDX_EXT_PRIORITY): next_st.ext_priority = st.w_data;
				reg_addr(IDX_VECTOR_ENABLE): next_st.vector_enable = st.w_data;
				reg_addr(IDX_ENTRY_INDEX): next_st.entry_index = st.w_data[2:0];
				reg_addr(IDX_LEGACY_CONTROL): next_st.legacy_control = st.w_data[3:0];
				reg_addr(IDX_IRQ_CLEAR): irq_clr = st.w_data[1:0];
				reg_addr(IDX_IRQ_ENABLE): next_st.irq_enable = st.w_data[1:0];
				default: next_st.legacy_control = st.legacy_control;
			endcase
		end

		// Read answers one cycle after the address is taken
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = read_word(st, ar_addr);
			next_st.rresp = mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Flags: a new edge beats a clear in the same cycle
		next_st.ext_pending_flags = (st.ext_pending_flags & ~ext_clr) | ext_edge;
		next_st.irq_status = (st.irq_status & ~irq_clr) | src_edge[1:0];
		next_st.wake = |src_edge;

		// Arbiter: scan downward so the lowest number is left standing
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req10[i] && prio10[i]) begin
				hf = 1'b1;
				hid = 4'(i);
			end
			if (req10[i] && !prio10[i]) begin
				lf = 1'b1;
				lid = 4'(i);
			end
		end
		next_st.vec_valid = hf | lf;
		next_st.vec_id = hf ? hid : lid;
	end

	// State register; pin select straps load their documented values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.legacy0_pin_index <= LEGACY0_PIN_RESET;
			st.legacy1_pin_index <= LEGACY1_PIN_RESET;
		end else begin
			st <= next_st;
		end
	end

	// An edge beats a clear that lands in the same cycle
	a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		(ext_edge != 8'h00) |=> ((st.ext_pending_flags & $past(ext_edge)) == $past(ext_edge)))
		else $error("edge lost from pending flags");

	// Legacy status is sticky on its own edges
	a_legacy_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_edge[1:0] != 2'h0) |=> ((st.irq_status & $past(src_edge[1:0])) == $past(src_edge[1:0])))
		else $error("legacy edge lost from status");

	// Flags never rise without an edge, so no register write can set one
	a_flag_needs_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(ext_edge == 8'h00) |=> ((st.ext_pending_flags & ~$past(st.ext_pending_flags)) == 8'h00))
		else $error("pending flag rose without an edge");

	// Writing 1 clears a flag, writing 0 keeps it
	a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && st.aw_addr == reg_addr(IDX_EXT_PENDING_FLAGS) && ext_edge == 8'h00)
		|=> ((st.ext_pending_flags & $past(st.w_data)) == 8'h00)
		&& ((st.ext_pending_flags & ~$past(st.w_data)) == ($past(st.ext_pending_flags) & ~$past(st.w_data))))
		else $error("write-one clear misbehaved");

	// Config writes go to the entry picked by the index register
	a_index_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && st.aw_addr == reg_addr(IDX_EXT_ENTRY_CONFIG))
		|=> st.entry_cfg[$past(st.entry_index)].entry_pin_index == $past(st.w_data[5:0]))
		else $error("config write not routed by index");

	// Legacy 0 pin select takes the low five data bits
	a_legacy0_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && st.aw_addr == reg_addr(IDX_LEGACY0_PIN_SELECT))
		|=> st.legacy0_pin_index == $past(st.w_data[4:0]))
		else $error("legacy 0 pin select not written");

	// Legacy 1 pin select takes the low five data bits
	a_legacy1_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && st.aw_addr == reg_addr(IDX_LEGACY1_PIN_SELECT))
		|=> st.legacy1_pin_index == $past(st.w_data[4:0]))
		else $error("legacy 1 pin select not written");

	// Enables are those the arbiter saw a cycle ago, since the grant is registered
	a_request_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.vec_valid && st.vec_id >= 4'h2)
		|-> ((($past(st.vector_enable & st.ext_source_enable) >> (st.vec_id - 4'h2)) & 8'h01) != 8'h00))
		else $error("vector granted without both enables");

	// Any high request forces a high grant
	a_high_first: assert property (@(posedge aclk) disable iff (!aresetn)
		(|(req10 & prio10)) |=> st.vec_valid && ((($past(prio10) >> st.vec_id) & 10'h001) != 10'h000))
		else $error("low priority served over high");

	// No lower source of the winner's priority may be left waiting
	a_natural_order: assert property (@(posedge aclk) disable iff (!aresetn)
		st.vec_valid |-> ($past(req10) & ((10'h001 << st.vec_id) - 10'h001)
		& ~($past(prio10) ^ {10{((($past(prio10) >> st.vec_id) & 10'h001) != 10'h000)}})) == 10'h000)
		else $error("higher vector served before lower of same priority");

	// No request, no vector
	a_vec_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(req10 == 10'h000) |=> !st.vec_valid)
		else $error("vector offered with no request");

	// Every edge cycle gives one wake cycle
	a_wake_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_edge != 10'h000) |=> wake_request)
		else $error("edge did not raise wake");

	// Wake stays low without an edge, so stop mode is not left for nothing
	a_wake_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_edge == 10'h000) |=> !wake_request)
		else $error("wake raised without an edge");

	// Reset leaves every source disabled
	a_enable_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> st.ext_source_enable == 8'h00 && st.ext_pending_flags == 8'h00)
		else $error("enables not cleared by reset");

	// Byte 0 strobe low means the write is ignored
	a_strobe_skip: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && !st.w_strb0) |=> (st.ext_source_enable == $past(st.ext_source_enable))
		&& (st.ext_priority == $past(st.ext_priority)) && (st.entry_index == $past(st.entry_index)))
		else $error("write with byte 0 strobe off changed a register");

	// Write response stands until taken
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

	// Read data stands until taken
	a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	// Unmapped write words answer with an error
	a_slverr_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && !mapped(st.aw_addr)) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("unmapped write not refused");

	// Unmapped read words return zero with an error
	a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr))
		|=> (s_axi_rvalid && s_axi_rdata == 32'h00000000 && s_axi_rresp == RESP_SLVERR))
		else $error("unmapped read not refused");

	// Registers are one byte wide; upper bits read zero
	a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
		else $error("read data upper bits not zero");
endmodule : external_interrupt_select

//--- rtl/pin_edge_detect.sv
// Selects one synchronised pin and flags its chosen edge
`timescale 1ns/1ps
module pin_edge_detect import ext_irq_pkg::*; #(
	parameter int PINS = NUM_PINS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [PINS-1:0] pins,
	input wire entry_cfg_type cfg,
	output logic edge_seen
);
	edge_state_type st;
	edge_state_type next_st;
	logic in_range;
	logic level;

	// Out of range index selects nothing
	assign in_range = (cfg.entry_pin_index < 6'(PINS));
	assign level = in_range ? pins[cfg.entry_pin_index] : 1'b0;

	// A fresh index suppresses one compare so a pin swap is not taken for an edge
	always_comb begin
		next_st.prev = level;
		next_st.last_index = cfg.entry_pin_index;
		edge_seen = 1'b0;
		if (in_range && st.last_index == cfg.entry_pin_index) begin
			edge_seen = cfg.edge_polarity ? (st.prev & ~level) : (~st.prev & level);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_no_pin_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		!in_range |-> !edge_seen) else $error("edge flagged for an unmapped pin index");
	a_edge_dir: assert property (@(posedge aclk) disable iff (!aresetn)
		edge_seen |-> (cfg.edge_polarity ? $fell(level) : $rose(level))) else $error("edge of wrong direction");
endmodule : pin_edge_detect

//--- tb/external_interrupt_select_tb_top.sv
// Self-checking bench for the external interrupt selector
`timescale 1ns/1ps
module external_interrupt_select_tb_top import ext_irq_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [NUM_PINS-1:0] pin_req = '0;
	logic [NUM_PINS-1:0] port_pins;
	logic [NUM_PINS-1:0] mp = '0;
	logic [ADDR_W-1:0] awa = '0;
	logic [ADDR_W-1:0] ara = '0;
	logic [31:0] wd = '0;
	logic [3:0] ws = 4'hF;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bry = 1'b0;
	logic arv = 1'b0;
	logic rry = 1'b0;
	logic awr, wrd, bv, arr, rv, l0, l1, vv, wk, irq;
	logic [1:0] br, rr, resp;
	logic [31:0] rdat, d;
	logic [NUM_EXT-1:0] req;
	logic [3:0] vid;
	// Reference model of registers, flags and pin levels
	logic [7:0] flags = '0, src_en = '0, vec_en = '0, prio = '0;
	logic [1:0] stat = '0, irq_en = '0;
	logic [3:0] lctl = '0;
	int lpin[2] = '{26, 27};
	int epin[8] = '{default: 0};
	logic epol[8] = '{default: 1'b0};
	int bad_count = 0, samples_checked = 0, wake_seen = 0, wake_exp = 0;

	pin_source_model far_pins (.aclk(aclk), .level_req(pin_req), .port_pins(port_pins));
	external_interrupt_select dut (.aclk(aclk), .aresetn(aresetn), .port_pins(port_pins),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .ext_request(req), .legacy_ext_irq0(l0), .legacy_ext_irq1(l1),
		.vec_valid(vv), .vec_id(vid), .wake_request(wk), .irq(irq));

	// Clock, and a count of wake pulses as the power controller would see them
	always #25 aclk = ~aclk;
	always @(posedge aclk) if (wk === 1'b1) wake_seen++;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// Write holds each channel until taken; the spare edge keeps bready from toggling twice
	task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] r);
		awa <= ADDR_W'({idx, 2'b00});
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		r = br;
		bry <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
		wr(idx, v, resp);
		check(resp, RESP_OKAY);
	endtask : wreg

	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		ara <= ADDR_W'({idx, 2'b00});
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdat;
		resp = rr;
		rry <= 1'b0;
		@(posedge aclk);
		check(d, {24'h0, e});
	endtask : rchk

	function automatic logic hp(input int i);
		return (i < 2) ? lctl[2 + i] : prio[i - 2];
	endfunction : hp

	function automatic logic [NUM_PINS-1:0] flip(input int p);
		return mp ^ (NUM_PINS'(1) << p);
	endfunction : flip

	// Compare every request output and the flag registers with the model
	task automatic verify();
		logic [9:0] r;
		int best;
		r = {flags & src_en & vec_en, stat & irq_en};
		best = -1;
		for (int i = 9; i >= 0; i--) if (r[i] && (best < 0 || hp(i) >= hp(best))) best = i;
		check(req, r[9:2]);
		check({l1, l0}, r[1:0]);
		check(irq, |r);
		check(vv, |r);
		if (best >= 0) check(vid, 4'(best));
		check(wake_seen, wake_exp);
		rchk(IDX_EXT_PENDING_FLAGS, flags);
		rchk(IDX_IRQ_STATUS, {6'h0, stat});
	endtask : verify

	// Model the edges a new pin pattern makes, then hand it to the pin model
	task automatic model(input logic [NUM_PINS-1:0] nv);
		logic hit;
		hit = 1'b0;
		for (int e = 0; e < NUM_EXT; e++)
			if (epin[e] < NUM_PINS && nv[epin[e]] != mp[epin[e]] && nv[epin[e]] != epol[e]) begin
				flags[e] = 1'b1;
				hit = 1'b1;
			end
		for (int l = 0; l < 2; l++)
			if (nv[lpin[l]] != mp[lpin[l]] && nv[lpin[l]] != lctl[l]) begin
				stat[l] = 1'b1;
				hit = 1'b1;
			end
		if (hit) wake_exp++;
		mp = nv;
		pin_req <= nv;
	endtask : model

	task automatic step(input logic [NUM_PINS-1:0] nv);
		model(nv);
		repeat (8) @(posedge aclk);
		verify();
	endtask : step

	// Main sequence
	initial begin
		void'($urandom(32'hE7D7));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(IDX_LEGACY0_PIN_SELECT, 8'h1A);
		rchk(IDX_LEGACY1_PIN_SELECT, 8'h1B);
		rchk(IDX_EXT_SOURCE_ENABLE, 8'h00);
		rchk(IDX_EXT_PRIORITY, 8'h00);
		rchk(8'h00, 8'h00);
		check(resp, RESP_SLVERR);
		wr(8'h00, 8'hFF, resp);
		check(resp, RESP_SLVERR);
		$display("test reset and map done");
		for (int e = 0; e < NUM_EXT; e++) begin
			epin[e] = (e == 7) ? 45 : e * 5 + int'($urandom % 5);
			epol[e] = 1'($urandom);
			wreg(IDX_ENTRY_INDEX, 8'(e));
			wreg(IDX_EXT_ENTRY_CONFIG, {epol[e], 1'b0, 6'(epin[e])});
		end
		for (int e = 7; e >= 0; e--) begin
			wreg(IDX_ENTRY_INDEX, 8'(e));
			rchk(IDX_EXT_ENTRY_CONFIG, {epol[e], 1'b0, 6'(epin[e])});
		end
		src_en = 8'($urandom);
		vec_en = 8'hFF;
		prio = 8'($urandom);
		lctl = 4'($urandom);
		irq_en = 2'h3;
		lpin = '{8, 31};
		wreg(IDX_EXT_SOURCE_ENABLE, src_en);
		wreg(IDX_VECTOR_ENABLE, vec_en);
		wreg(IDX_EXT_PRIORITY, prio);
		wreg(IDX_LEGACY_CONTROL, {4'h0, lctl});
		wreg(IDX_IRQ_ENABLE, 8'h03);
		wreg(IDX_LEGACY0_PIN_SELECT, 8'h08);
		wreg(IDX_LEGACY1_PIN_SELECT, 8'h1F);
		rchk(IDX_EXT_SOURCE_ENABLE, src_en);
		ws <= 4'h0;
		wreg(IDX_EXT_PRIORITY, 8'h00);
		ws <= 4'hF;
		rchk(IDX_EXT_PRIORITY, prio);
		$display("test configuration done");
		for (int e = 0; e < NUM_EXT; e++) begin
			step(flip(epin[e]));
			step(flip(epin[e]));
		end
		for (int l = 0; l < 2; l++) begin
			step(flip(lpin[l]));
			step(flip(lpin[l]));
		end
		wreg(IDX_EXT_PENDING_FLAGS, 8'h00);
		verify();
		d = $urandom;
		wreg(IDX_EXT_PENDING_FLAGS, d[7:0]);
		flags &= ~d[7:0];
		verify();
		wreg(IDX_IRQ_CLEAR, 8'h01);
		stat[0] = 1'b0;
		irq_en = 2'h2;
		vec_en = 8'($urandom);
		wreg(IDX_IRQ_ENABLE, 8'h02);
		wreg(IDX_VECTOR_ENABLE, vec_en);
		step(flip(lpin[0]));
		step(flip(lpin[0]));
		epin[3] = 50;
		wreg(IDX_ENTRY_INDEX, 8'h03);
		wreg(IDX_EXT_ENTRY_CONFIG, {epol[3], 7'h32});
		step(~mp);
		step(~mp);
		if (mp[epin[0]] != epol[0]) step(flip(epin[0]));
		wreg(IDX_EXT_PENDING_FLAGS, 8'hFF);
		flags = '0;
		// Edge lands on the very edge that applies the clear
		model(flip(epin[0]));
		repeat (2) @(posedge aclk);
		wreg(IDX_EXT_PENDING_FLAGS, 8'h01);
		repeat (8) @(posedge aclk);
		verify();
		$display("test edges and clears done");
		results();
	end

	// Cut a hang short; the sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		results();
	end
endmodule : external_interrupt_select_tb_top

//--- tb/pin_source_model.sv
// Behavioural model of the port pins that feed the selector
`timescale 1ns/1ps
module pin_source_model import ext_irq_pkg::*; (
	input wire logic aclk,
	input wire logic [NUM_PINS-1:0] level_req,
	output logic [NUM_PINS-1:0] port_pins
);
	// Pins move just after an edge, so the selector never samples a half-changed bus
	initial port_pins = '0;
	always @(posedge aclk) begin
		port_pins <= level_req;
	end
endmodule : pin_source_model
